// ==== common/kmd_map.vh ====
/*
 * Constants for the keyboard matrix command decoder: scan timing, strobe
 * pulse timing, debounce depths, display mode codes and command codes.
 * Assumes a 100 MHz clock and line and field pulses from the display timing.
 */
`ifndef KMD_MAP_VH
`define KMD_MAP_VH

// -----------------------------------------------------------------------
// Clock and strobe timing
// -----------------------------------------------------------------------
`define KMD_CLK_NS        10
`define KMD_PULSE_NS      12
`define KMD_DEAD_NS       6
// Least times round up to whole cycles
`define KMD_PULSE_CYC     ((`KMD_PULSE_NS + `KMD_CLK_NS - 1) / `KMD_CLK_NS)
`define KMD_DEAD_CYC      ((`KMD_DEAD_NS + `KMD_CLK_NS - 1) / `KMD_CLK_NS)
`define KMD_FIELD_MS      20
`define KMD_SCAN_LINE     9'h00a
`define KMD_STRB_GAP      8
`define KMD_SCAN_LEN      6'h20

// -----------------------------------------------------------------------
// Debounce depths in fields
// -----------------------------------------------------------------------
`define KMD_KEY_FIELDS    2'h2
`define KMD_REVEAL_FIELDS 2'h3

// -----------------------------------------------------------------------
// Display modes and command codes {column, row}
// -----------------------------------------------------------------------
`define KMD_MODE_PICT     2'h0
`define KMD_MODE_MIX      2'h1
`define KMD_MODE_TEXT     2'h2
`define KMD_MODE_RESET    2'h0
`define KMD_CMD_PAGE      4'ha
`define KMD_CMD_TIME      4'hb
`define KMD_CMD_TEXT      4'hc
`define KMD_CMD_MIX       4'hd
`define KMD_CMD_PICT      4'he
`define KMD_CMD_UPDATE    4'hf

`endif

// ==== verilog/kmd_top.v ====
/*
 * Keyboard matrix command decoder with display mode and video gating.
 * Assumes line_sync_in and field_sync_in are one-cycle pulses synchronous
 * to clk_in, that the strobe and return wires carry external pull-ups,
 * and that pixel and box qualifiers come from the character generator.
 */
`include "kmd_map.vh"
`default_nettype none

module kmd_top (
    // Clock, reset, enable
    input  wire       clk_in,
    input  wire       arst_n_in,
    input  wire       ce_in,
    // Display timing
    input  wire       field_sync_in,
    input  wire       line_sync_in,
    // Keyboard strobe pins (open drain) and return lines
    input  wire [3:0] strobe_in,
    output reg  [3:0] strobe_out,
    output reg  [3:0] strobe_oe_out,
    input  wire [3:0] return_in,
    // Character generator
    input  wire       active_in,
    input  wire       pix_fg_in,
    input  wire [2:0] pix_rgb_in,
    input  wire       boxed_page_in,
    input  wire       box_area_in,
    // Commands
    output reg        cmd_valid_out,
    output reg  [3:0] cmd_code_out,
    output reg        reveal_out,
    output reg  [1:0] mode_out,
    // Video
    output reg        blank_out,
    output reg  [2:0] rgb_out,
    output reg        mono_out
);

    // -------------------------------------------------------------------
    // Constants sized for the counters they meet
    // -------------------------------------------------------------------
    localparam [5:0] GAP   = `KMD_STRB_GAP;
    localparam [5:0] PW    = `KMD_PULSE_CYC;
    localparam [5:0] DEAD  = `KMD_DEAD_CYC;

    // Strobe k is pulled low in its own slot of the scan line
    function strobe_on;
        input [5:0] tick;
        input [1:0] k;
        reg   [5:0] base;
        begin
            base      = {1'b0, k, 3'h0};
            strobe_on = (tick >= base) && (tick < base + PW);
        end
    endfunction

    // -------------------------------------------------------------------
    // Line counting and scan window
    // -------------------------------------------------------------------
    reg  [8:0] line_q;
    reg        scan_q;
    reg  [5:0] tick_q;

    // Scan runs once per field on one line only
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            line_q <= 9'h000;
            scan_q <= 1'b0;
            tick_q <= 6'h00;
        end else if (ce_in) begin
            if (field_sync_in) begin
                line_q <= 9'h000;
            end else if (line_sync_in) begin
                line_q <= line_q + 9'h001;
            end
            if (line_sync_in && !field_sync_in && line_q == `KMD_SCAN_LINE) begin
                scan_q <= 1'b1;
                tick_q <= 6'h00;
            end else if (scan_q) begin
                tick_q <= tick_q + 6'h01;
                if (tick_q == `KMD_SCAN_LEN - 6'h01) begin
                    scan_q <= 1'b0;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Strobe drive: low only while pulsing, released otherwise
    // -------------------------------------------------------------------
    integer s;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            strobe_out    <= 4'hf;
            strobe_oe_out <= 4'h0;
        end else if (ce_in) begin
            for (s = 0; s < 4; s = s + 1) begin
                // Pull-ups hold the pin high when oe is low
                strobe_oe_out[s] <= scan_q && strobe_on(tick_q, s[1:0]);
            end
            // Drive value is low after reset (reset loads 4'hf); only the enable moves the pin
            strobe_out <= 4'h0;
        end
    end

    // -------------------------------------------------------------------
    // Return sampling during the field's scan
    // -------------------------------------------------------------------
    reg  [3:0] hit_code_q;
    reg  [2:0] hit_cnt_q;
    reg        strb1_low_q;
    reg  [1:0] col;
    reg  [5:0] samp;
    reg        in_samp;
    integer r;

    // Registered strobe oe is one cycle behind tick, so pulse k is on the
    // pin for ticks k*GAP+1 .. k*GAP+PW; the sample skips the dead part
    always @* begin
        col     = tick_q[4:3];
        samp    = {1'b0, col, 3'h0} + 6'h01 + DEAD;
        in_samp = scan_q && tick_q == samp && tick_q < GAP * 6'h04;
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hit_code_q  <= 4'h0;
            hit_cnt_q   <= 3'h0;
            strb1_low_q <= 1'b0;
        end else if (ce_in) begin
            if (field_sync_in) begin
                hit_cnt_q   <= 3'h0;
                strb1_low_q <= 1'b0;
            end else if (in_samp) begin
                for (r = 0; r < 4; r = r + 1) begin
                    if (!return_in[r]) begin
                        hit_code_q <= {col, r[1:0]};
                    end
                end
                hit_cnt_q <= hit_cnt_q + {2'h0, ~return_in[0]}
                           + {2'h0, ~return_in[1]}
                           + {2'h0, ~return_in[2]}
                           + {2'h0, ~return_in[3]};
                // Strobe 0 low while column 1 pulses is a hold
                if (col == 2'h1 && !strobe_in[0]) begin
                    strb1_low_q <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Field-rate debounce of keys and of the reveal hold
    // -------------------------------------------------------------------
    reg  [3:0] last_code_q;
    reg  [1:0] same_q;
    reg        fired_q;
    reg  [1:0] rev_cnt_q;
    reg        rev_fired_q;
    reg  [1:0] mode_next_q;
    reg        one_hit;

    always @* begin
        // Two keys at once are ambiguous and count as none
        one_hit = (hit_cnt_q == 3'h1);
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            last_code_q   <= 4'h0;
            same_q        <= 2'h0;
            fired_q       <= 1'b0;
            rev_cnt_q     <= 2'h0;
            rev_fired_q   <= 1'b0;
            cmd_valid_out <= 1'b0;
            cmd_code_out  <= 4'h0;
            reveal_out    <= 1'b0;
            mode_next_q   <= `KMD_MODE_RESET;
            mode_out      <= `KMD_MODE_RESET;
        end else if (ce_in) begin
            cmd_valid_out <= 1'b0;
            if (field_sync_in) begin
                mode_out <= mode_next_q;
                if (!one_hit) begin
                    same_q  <= 2'h0;
                    fired_q <= 1'b0;
                end else if (hit_code_q != last_code_q || same_q == 2'h0) begin
                    last_code_q <= hit_code_q;
                    same_q      <= 2'h1;
                    fired_q     <= 1'b0;
                end else begin
                    if (same_q != 2'h3) begin
                        same_q <= same_q + 2'h1;
                    end
                    // Fire once per press after the second matching field
                    if (!fired_q && same_q + 2'h1 >= `KMD_KEY_FIELDS) begin
                        fired_q       <= 1'b1;
                        cmd_valid_out <= 1'b1;
                        cmd_code_out  <= hit_code_q;
                        if (hit_code_q == `KMD_CMD_TEXT) begin
                            mode_next_q <= `KMD_MODE_TEXT;
                        end else if (hit_code_q == `KMD_CMD_MIX) begin
                            mode_next_q <= `KMD_MODE_MIX;
                        end else if (hit_code_q == `KMD_CMD_PICT) begin
                            mode_next_q <= `KMD_MODE_PICT;
                        end
                    end
                end
                // Reveal toggles once per sustained hold
                if (!strb1_low_q) begin
                    rev_cnt_q   <= 2'h0;
                    rev_fired_q <= 1'b0;
                end else begin
                    if (rev_cnt_q != 2'h3) begin
                        rev_cnt_q <= rev_cnt_q + 2'h1;
                    end
                    if (!rev_fired_q && rev_cnt_q + 2'h1 == `KMD_REVEAL_FIELDS) begin
                        rev_fired_q <= 1'b1;
                        reveal_out  <= ~reveal_out;
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Video gating by mode
    // -------------------------------------------------------------------
    reg       blank_d;
    reg [2:0] rgb_d;
    reg       mono_d;

    always @* begin
        blank_d = 1'b0;
        rgb_d   = 3'h0;
        mono_d  = active_in && pix_fg_in;
        if (mode_out == `KMD_MODE_TEXT) begin
            if (boxed_page_in) begin
                // Picture stays visible; only the box area is blanked
                blank_d = box_area_in;
                rgb_d   = box_area_in ? pix_rgb_in : 3'h0;
                mono_d  = mono_d && box_area_in;
            end else begin
                blank_d = active_in;
                rgb_d   = active_in ? pix_rgb_in : 3'h0;
            end
        end else if (mode_out == `KMD_MODE_MIX) begin
            // Colour is dropped so text stays legible on any picture
            rgb_d = {3{active_in && pix_fg_in}};
        end else begin
            mono_d = 1'b0;
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            blank_out <= 1'b0;
            rgb_out   <= 3'h0;
            mono_out  <= 1'b0;
        end else if (ce_in) begin
            blank_out <= blank_d;
            rgb_out   <= rgb_d;
            mono_out  <= mono_d;
        end
    end

endmodule // kmd_top

`default_nettype wire

// ==== test/kmd_chk.sv ====
/* Checker for kmd_top: strobe timing, command timing and video gating.
   Assumes ce_in is held high and that it is bound to kmd_top. */
`include "kmd_map.vh"
`default_nettype none
module kmd_chk (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       arst_n_in,
    // Timing and video qualifiers
    input wire logic       field_sync_in,
    input wire logic       active_in,
    input wire logic       pix_fg_in,
    input wire logic       boxed_page_in,
    input wire logic       box_area_in,
    // Design outputs
    input wire logic [3:0] strobe_oe_out,
    input wire logic       cmd_valid_out,
    input wire logic [3:0] cmd_code_out,
    input wire logic       reveal_out,
    input wire logic [1:0] mode_out,
    input wire logic       blank_out,
    input wire logic [2:0] rgb_out,
    input wire logic       mono_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic [2:0] oe0_cnt_q;

    // ------------------------------------------
    // Strobe 0 cycles in this field, saturating
    // ------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            oe0_cnt_q <= 3'h0;
        else if (field_sync_in)
            oe0_cnt_q <= 3'h0;
        else if (strobe_oe_out[0] && oe0_cnt_q != 3'h7)
            oe0_cnt_q <= oe0_cnt_q + 3'h1;
    end

    AST_ONE_COL: assert property ($onehot0(strobe_oe_out))
        else $error("two strobes driven together");
    AST_PULSE_LEN: assert property (
        $rose(|strobe_oe_out) |=> $stable(strobe_oe_out) ##1 strobe_oe_out == 4'h0)
        else $error("strobe pulse length wrong");
    AST_STAGGER: assert property (
        $rose(strobe_oe_out[0]) |-> ##8 strobe_oe_out == 4'h2
        ##8 strobe_oe_out == 4'h4 ##8 strobe_oe_out == 4'h8) else $error("strobe slots wrong");
    AST_PER_FIELD: assert property (oe0_cnt_q <= 3'h2)
        else $error("strobe repeated within a field");
    AST_CMD_AT_FIELD: assert property (cmd_valid_out |-> $past(field_sync_in)
        && !$past(cmd_valid_out)) else $error("command pulse off field edge");
    AST_REVEAL_AT_FIELD: assert property (
        $changed(reveal_out) |-> $past(field_sync_in))
        else $error("reveal changed off field edge");
    AST_MODE_NEXT_FIELD: assert property (
        $changed(mode_out) |-> $past(field_sync_in))
        else $error("mode changed off field edge");
    AST_MODE_FROM_CMD: assert property ($changed(mode_out) |-> mode_out ==
        (cmd_code_out == `KMD_CMD_TEXT ? `KMD_MODE_TEXT : cmd_code_out == `KMD_CMD_MIX ?
        `KMD_MODE_MIX : `KMD_MODE_PICT)) else $error("mode differs from command");
    AST_TEXT_BLANK: assert property (
        $past(mode_out == `KMD_MODE_TEXT && !boxed_page_in)
        |-> blank_out == $past(active_in)) else $error("text blanking wrong");
    AST_BOX_BLANK: assert property (
        $past(mode_out == `KMD_MODE_TEXT && boxed_page_in)
        |-> blank_out == $past(box_area_in)) else $error("box blanking wrong");
    AST_MIX_WHITE: assert property ($past(mode_out == `KMD_MODE_MIX) |-> !blank_out &&
        rgb_out == {3{$past(active_in && pix_fg_in)}}) else $error("mix colour wrong");
    AST_MONO: assert property ($past(mode_out != `KMD_MODE_TEXT || !boxed_page_in) |->
        mono_out == $past(mode_out != `KMD_MODE_PICT && active_in && pix_fg_in))
        else $error("mono output wrong");

    // Main scenarios reached
    cover property (cmd_valid_out && cmd_code_out == `KMD_CMD_TEXT);
    cover property ($changed(reveal_out));
    cover property (mode_out == `KMD_MODE_TEXT && boxed_page_in && box_area_in);
endmodule // kmd_chk

bind kmd_top kmd_chk u_chk (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .field_sync_in(field_sync_in),
    .active_in(active_in), .pix_fg_in(pix_fg_in), .boxed_page_in(boxed_page_in),
    .box_area_in(box_area_in), .strobe_oe_out(strobe_oe_out), .cmd_valid_out(cmd_valid_out),
    .cmd_code_out(cmd_code_out), .reveal_out(reveal_out), .mode_out(mode_out),
    .blank_out(blank_out), .rgb_out(rgb_out), .mono_out(mono_out));
`default_nettype wire

// ==== test/kmd_keypad.sv ====
/* Keypad model on the strobe and return pins.
   Assumes pull-ups on every pin and at most one key closed. */
`default_nettype none
module kmd_keypad (
    // Device strobe drive
    input  wire logic [3:0] strobe_oe_in,
    // Key and reveal switch
    input  wire logic       key_on_in,
    input  wire logic [1:0] key_col_in,
    input  wire logic [1:0] key_row_in,
    input  wire logic       reveal_hold_in,
    // Resolved pin levels
    output logic      [3:0] strobe_pin_out,
    output logic      [3:0] return_pin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pull-up unless the device or the reveal switch pulls low
    assign strobe_pin_out = ~strobe_oe_in & {3'h7, ~reveal_hold_in};
    // Zero delay routing stays well inside the dead start of a pulse.
    // Keys reach only the decoder, never a channel selector
    always_comb begin
        return_pin_out = 4'hf;
        if (key_on_in)
            return_pin_out[key_row_in] = strobe_pin_out[key_col_in];
    end
endmodule // kmd_keypad
`default_nettype wire

// ==== test/tb_kmd_top.sv ====
/* Testbench for kmd_top: keys, debounce, reveal, reset mode, video.
   Assumes kmd_keypad on the pins and kmd_chk bound to the design. */
`include "kmd_map.vh"
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module tb_kmd_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_in = 1'b0;
    logic       arst_n_in = 1'b0;
    logic       field_sync_in, line_sync_in, active_in, pix_fg_in, boxed_page_in, box_area_in;
    logic [2:0] pix_rgb_in, rgb_out;
    logic [3:0] strobe_in, strobe_out, strobe_oe_out, return_in, cmd_code_out;
    logic       cmd_valid_out, reveal_out, blank_out, mono_out, key_on, reveal_hold;
    logic [1:0] mode_out, key_col, key_row, exp_mode;
    integer     seed = 57;
    integer     n_mismatch = 0;
    integer     n_compared = 0;
    integer     n_cmd = 0;

    kmd_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
        .field_sync_in(field_sync_in), .line_sync_in(line_sync_in), .strobe_in(strobe_in),
        .strobe_out(strobe_out), .strobe_oe_out(strobe_oe_out), .return_in(return_in),
        .active_in(active_in), .pix_fg_in(pix_fg_in), .pix_rgb_in(pix_rgb_in),
        .boxed_page_in(boxed_page_in), .box_area_in(box_area_in),
        .cmd_valid_out(cmd_valid_out), .cmd_code_out(cmd_code_out), .reveal_out(reveal_out),
        .mode_out(mode_out), .blank_out(blank_out), .rgb_out(rgb_out), .mono_out(mono_out));
    kmd_keypad u_pad (.strobe_oe_in(strobe_oe_out), .key_on_in(key_on), .key_col_in(key_col),
        .key_row_in(key_row), .reveal_hold_in(reveal_hold), .strobe_pin_out(strobe_in),
        .return_pin_out(return_in));

    // ------------------------------------------
    // Clock, command counter, random pixels
    // ------------------------------------------
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (cmd_valid_out === 1'b1) n_cmd++;
    always @(posedge clk_in) begin
        #1 {active_in, pix_fg_in, pix_rgb_in, box_area_in} = 6'($random(seed));
    end

    // Short fields keep the run small; twelve lines leave room after the scan line
    task run_field(input integer n);
        repeat (n) begin
            @(posedge clk_in);
            #1 field_sync_in = 1'b1;
            boxed_page_in = 1'($random(seed));
            @(posedge clk_in);
            #1 field_sync_in = 1'b0;
            repeat (12) begin
                repeat (35) @(posedge clk_in);
                #1 line_sync_in = 1'b1;
                @(posedge clk_in);
                #1 line_sync_in = 1'b0;
            end
        end
    endtask

    // Close one key for some fields, then leave a two field gap
    task press(input logic [3:0] code, input integer on_f, input integer exp_n);
        integer c0;
        c0 = n_cmd;
        {key_col, key_row} = code;
        key_on = 1'b1;
        run_field(on_f);
        key_on = 1'b0;
        run_field(2);
        if (exp_n > 0 && code == `KMD_CMD_TEXT) exp_mode = `KMD_MODE_TEXT;
        if (exp_n > 0 && code == `KMD_CMD_MIX) exp_mode = `KMD_MODE_MIX;
        if (exp_n > 0 && code == `KMD_CMD_PICT) exp_mode = `KMD_MODE_PICT;
        `CHK("command count", exp_n, n_cmd - c0)
        if (exp_n > 0) `CHK("command code", code, cmd_code_out)
        `CHK("display mode", exp_mode, mode_out)
    endtask

    task complete_run;
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        complete_run;
    end

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        {field_sync_in, line_sync_in, boxed_page_in, key_on, reveal_hold} = 5'h00;
        {active_in, pix_fg_in, pix_rgb_in, box_area_in, key_col, key_row} = 10'h000;
        exp_mode = `KMD_MODE_PICT;
        repeat (3) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        `CHK("strobe enables", 4'h0, strobe_oe_out)
        press(`KMD_CMD_TEXT, 1, 0);
        `CHK("strobe drive", 4'h0, strobe_out)
        for (int i = 0; i < 16; i++) press(4'(i), 2 + ($random(seed) & 1), 1);
        press(`KMD_CMD_TEXT, 2, 1);
        reveal_hold = 1'b1;
        run_field(2);
        reveal_hold = 1'b0;
        run_field(2);
        `CHK("short reveal", 1'b0, reveal_out)
        reveal_hold = 1'b1;
        run_field(3);
        reveal_hold = 1'b0;
        run_field(2);
        `CHK("reveal", 1'b1, reveal_out)
        @(posedge clk_in);
        #1 arst_n_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        `CHK("reset mode", `KMD_MODE_PICT, mode_out)
        complete_run;
    end
endmodule // tb_kmd_top
`default_nettype wire
